// ===== verilog/temp_limit_pkg.sv
package temp_limit_pkg;

  // Register pointers on the link
  localparam logic [3:0] ADDR_CAP  = 4'h0;
  localparam logic [3:0] ADDR_CFG  = 4'h1;
  localparam logic [3:0] ADDR_HIGH = 4'h2;
  localparam logic [3:0] ADDR_LOW  = 4'h3;
  localparam logic [3:0] ADDR_CRIT = 4'h4;
  localparam logic [3:0] ADDR_TEMP = 4'h5;

  // Configuration bit positions
  localparam int CFG_MODE     = 0;
  localparam int CFG_POL      = 1;
  localparam int CFG_CRITONLY = 2;
  localparam int CFG_EN       = 3;
  localparam int CFG_MIRROR   = 4;
  localparam int CFG_CLEAR    = 5;
  localparam int CFG_ELOCK    = 6;
  localparam int CFG_CLOCK    = 7;
  localparam int CFG_SENSOR_SHUTDOWN     = 8;
  localparam int CFG_HYSTERESIS_SELECT_LO  = 9;
  localparam int CFG_HYSTERESIS_SELECT_HI  = 10;

  // Reading layout
  localparam int TEMP_FLAG_CRIT = 15;
  localparam int TEMP_FLAG_HIGH = 14;
  localparam int TEMP_FLAG_LOW  = 13;
  localparam int TEMP_SIGN      = 12;
  localparam int LIM_LSB        = 2;

  // Capability: 12-bit resolution, negative range, alarm and critical
  localparam logic [1:0]  RES_CAP   = 2'h3;
  localparam logic [15:0] CAP_VALUE = 16'h001d;

  // Hysteresis in sixteenths of a degree: 0, 1.5, 3, 6
  localparam logic signed [14:0] HYSTERESIS_SELECT_0 = 15'sh0000;
  localparam logic signed [14:0] HYSTERESIS_SELECT_1 = 15'sh0018;
  localparam logic signed [14:0] HYSTERESIS_SELECT_2 = 15'sh0030;
  localparam logic signed [14:0] HYSTERESIS_SELECT_3 = 15'sh0060;

  typedef enum logic [1:0] {MODE_CMP, MODE_INT, MODE_CRIT} alert_mode_t;

  // Bits kept for each resolution code
  function automatic logic [12:0] res_mask(input logic [1:0] code);
    logic [12:0] m;
    m = 13'h1fff;
    case (code)
      2'h0:    m = 13'h1ff8;
      2'h1:    m = 13'h1ffc;
      2'h2:    m = 13'h1ffe;
      default: m = 13'h1fff;
    endcase
    return m;
  endfunction

  // Sign extend a 13-bit reading to 15 bits for safe arithmetic
  function automatic logic signed [14:0] sx(input logic [12:0] v);
    return $signed({{2{v[TEMP_SIGN]}}, v});
  endfunction

endpackage

// ===== verilog/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  // Destination domain
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Crossing signal
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ===== verilog/temp_limit_event_logic.sv
`timescale 1ns/1ps
// Functional notes
// - Reading bit 15 set when temperature is at or above critical limit.
// - Reading bit 14 set only when temperature strictly exceeds high limit.
// - Reading bit 13 set only when temperature is strictly below low limit.
// - Bit 12 is the sign in reading and all three limits.
// - Reading is 13-bit two's complement, sixteenth-degree LSB, bits 12 to 0.
// - Each limit stored as 11-bit two's complement, quarter-degree LSB.
// - Limit bits 1 and 0 always read zero.
// - Reading bits below reported resolution read as zero.
// - Interrupt mode asserts on each window crossing until clear bit written.
// - Interrupt mode holds alert while above critical; clear cannot release it.
// - Clear while above critical is accepted, stored, executed once below.
// - Comparator mode asserts alert outside the low/high window.
// - Critical-only mode asserts only above critical; clears ignored.
// - Trip points come from limits combined with selected hysteresis.
// - Shutdown stops conversions and freezes the reading.
// - During shutdown the alert condition keeps its state from before the command; enable and polarity still gate the pin.
// - Reading updates per sample; limit writes re-evaluate alert immediately.
// - Hysteresis codes select 0, 1.5, 3 or 6 degrees.
// - Clear bit acts in interrupt mode only and reads back zero.
// - Read-only mirror of alert assertion, polarity free, gated by enable.
// - Shutdown refused while a lock bit is set; cancel always allowed.
module temp_limit_event_logic (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Link side register port
  input  wire logic        link_clk,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rd_valid,
  output logic             reg_busy,
  // Converter
  input  wire logic        sample_valid,
  input  wire logic [12:0] sample_temp,
  output logic             conv_enable,
  // Open-drain alert pin
  input  wire logic        alert_i,
  output logic             alert_o,
  output logic             alert_oe
);
  logic rst_n;
  logic rst_link_n;
  logic req_c;
  logic ack_l;

  // Resets assert at once and release through two flops per domain
  sync_2ff #(.W(1)) u_rst_sys  (.clk(clk),      .rst_n(reset_n), .d(1'b1), .q(rst_n));
  sync_2ff #(.W(1)) u_rst_link (.clk(link_clk), .rst_n(reset_n), .d(1'b1), .q(rst_link_n));

  // ---------------- Link domain: capture request, toggle handshake
  logic        req_q, req_d;
  logic        ack_seen_q, ack_seen_d;
  logic        write_l_q, write_l_d;
  logic [3:0]  addr_l_q, addr_l_d;
  logic [15:0] wdata_l_q, wdata_l_d;
  logic [15:0] rdata_q, rdata_d;
  logic        rd_valid_q, rd_valid_d;
  logic [15:0] xfer_rdata_q, xfer_rdata_d;
  logic        req_seen_q, req_seen_d;

  sync_2ff #(.W(1)) u_ack_sync (.clk(link_clk), .rst_n(rst_link_n), .d(req_seen_q), .q(ack_l));

  assign reg_busy = req_q ^ ack_seen_q;

  // Request fields stay put until the system side has answered
  always_comb begin
    req_d      = req_q;
    ack_seen_d = ack_seen_q;
    write_l_d  = write_l_q;
    addr_l_d   = addr_l_q;
    wdata_l_d  = wdata_l_q;
    rdata_d    = rdata_q;
    rd_valid_d = 1'b0;
    if (ack_l != ack_seen_q) begin
      ack_seen_d = ack_l;
      if (!write_l_q) begin
        rdata_d    = xfer_rdata_q;  // Stable: captured before the ack toggled
        rd_valid_d = 1'b1;
      end
    end
    if (!reg_busy && (reg_wr || reg_rd)) begin
      req_d     = ~req_q;
      write_l_d = reg_wr;           // Write wins if both strobes come together
      addr_l_d  = reg_addr;
      wdata_l_d = reg_wdata;
    end
  end

  always_ff @(posedge link_clk or negedge rst_link_n) begin
    if (!rst_link_n) begin
      req_q      <= 1'b0;
      ack_seen_q <= 1'b0;
      write_l_q  <= 1'b0;
      addr_l_q   <= 4'h0;
      wdata_l_q  <= 16'h0000;
      rdata_q    <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      req_q      <= req_d;
      ack_seen_q <= ack_seen_d;
      write_l_q  <= write_l_d;
      addr_l_q   <= addr_l_d;
      wdata_l_q  <= wdata_l_d;
      rdata_q    <= rdata_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign reg_rd_valid = rd_valid_q;

  // ---------------- System domain: registers, compare, alert
  sync_2ff #(.W(1)) u_req_sync (.clk(clk), .rst_n(rst_n), .d(req_q), .q(req_c));

  logic        mode_q, pol_q, critonly_q, en_q, elock_q, clock_q, sensor_shutdown_q;
  logic        mode_d, pol_d, critonly_d, en_d, elock_d, clock_d, sensor_shutdown_d;
  logic [1:0]  hysteresis_select_q, hysteresis_select_d;
  logic [10:0] high_q, low_q, crit_q, high_d, low_d, crit_d;
  logic [12:0] temp_q, temp_d;
  logic        crit_f_q, high_f_q, low_f_q, crit_f_d, high_f_d, low_f_d;
  logic        event_q, event_d, clr_pend_q, clr_pend_d;
  logic        cond_q, cond_d, oe_q, oe_d, conv_en_q, conv_en_d;
  logic        op_now, wr_now, rd_now, lock, int_mode, clr_req, do_clear, crossing;
  logic        ge_crit, gt_high, lt_low, active, cond_new;
  logic signed [14:0] t, lc, lh, ll, hv;
  temp_limit_pkg::alert_mode_t amode;

  assign op_now   = req_c != req_seen_q;
  assign wr_now   = op_now && write_l_q;
  assign rd_now   = op_now && !write_l_q;
  assign lock     = elock_q || clock_q;
  assign active   = en_q && cond_q;
  assign amode    = critonly_q ? temp_limit_pkg::MODE_CRIT :
                    (mode_q ? temp_limit_pkg::MODE_INT : temp_limit_pkg::MODE_CMP);
  assign int_mode = amode == temp_limit_pkg::MODE_INT;

  // Trip points in sixteenths; limits widened so that hysteresis cannot wrap
  always_comb begin
    t  = temp_limit_pkg::sx(temp_q);
    lc = temp_limit_pkg::sx({crit_q, 2'h0});
    lh = temp_limit_pkg::sx({high_q, 2'h0});
    ll = temp_limit_pkg::sx({low_q, 2'h0});
    case (hysteresis_select_q)
      2'h0:    hv = temp_limit_pkg::HYSTERESIS_SELECT_0;
      2'h1:    hv = temp_limit_pkg::HYSTERESIS_SELECT_1;
      2'h2:    hv = temp_limit_pkg::HYSTERESIS_SELECT_2;
      default: hv = temp_limit_pkg::HYSTERESIS_SELECT_3;
    endcase
  end

  assign ge_crit = t >= lc;
  assign gt_high = t > lh;
  assign lt_low  = t < ll;

  // Register writes, compare flags, event recording and alert state
  always_comb begin
    req_seen_d   = req_c;
    mode_d       = mode_q;
    pol_d        = pol_q;
    critonly_d   = critonly_q;
    en_d         = en_q;
    elock_d      = elock_q;
    clock_d      = clock_q;
    sensor_shutdown_d       = sensor_shutdown_q;
    hysteresis_select_d       = hysteresis_select_q;
    high_d       = high_q;
    low_d        = low_q;
    crit_d       = crit_q;
    temp_d       = temp_q;
    xfer_rdata_d = xfer_rdata_q;
    clr_req      = 1'b0;
    if (wr_now) begin
      case (addr_l_q)
        temp_limit_pkg::ADDR_CFG: begin
          if (!lock) begin
            mode_d = wdata_l_q[temp_limit_pkg::CFG_MODE];
            pol_d  = wdata_l_q[temp_limit_pkg::CFG_POL];
            en_d   = wdata_l_q[temp_limit_pkg::CFG_EN];
            hysteresis_select_d = wdata_l_q[temp_limit_pkg::CFG_HYSTERESIS_SELECT_HI:temp_limit_pkg::CFG_HYSTERESIS_SELECT_LO];
          end
          if (!elock_q || !wdata_l_q[temp_limit_pkg::CFG_CRITONLY]) begin
            critonly_d = wdata_l_q[temp_limit_pkg::CFG_CRITONLY];
          end
          elock_d = elock_q || wdata_l_q[temp_limit_pkg::CFG_ELOCK];
          clock_d = clock_q || wdata_l_q[temp_limit_pkg::CFG_CLOCK];
          if (!wdata_l_q[temp_limit_pkg::CFG_SENSOR_SHUTDOWN]) begin
            sensor_shutdown_d = 1'b0;                          // cancel always allowed
          end else if (!lock) begin
            sensor_shutdown_d = 1'b1;
          end
          clr_req = wdata_l_q[temp_limit_pkg::CFG_CLEAR] && int_mode;
        end
        temp_limit_pkg::ADDR_HIGH: if (!elock_q) high_d = wdata_l_q[12:temp_limit_pkg::LIM_LSB];
        temp_limit_pkg::ADDR_LOW:  if (!elock_q) low_d  = wdata_l_q[12:temp_limit_pkg::LIM_LSB];
        temp_limit_pkg::ADDR_CRIT: if (!clock_q) crit_d = wdata_l_q[12:temp_limit_pkg::LIM_LSB];
        default: ;
      endcase
    end
    if (rd_now) begin
      case (addr_l_q)
        temp_limit_pkg::ADDR_CAP:  xfer_rdata_d = temp_limit_pkg::CAP_VALUE;
        temp_limit_pkg::ADDR_CFG:  xfer_rdata_d = {5'h00, hysteresis_select_q, sensor_shutdown_q, clock_q, elock_q, 1'b0,
                                                   active, en_q, critonly_q, pol_q, mode_q};
        temp_limit_pkg::ADDR_HIGH: xfer_rdata_d = {3'h0, high_q, 2'h0};
        temp_limit_pkg::ADDR_LOW:  xfer_rdata_d = {3'h0, low_q, 2'h0};
        temp_limit_pkg::ADDR_CRIT: xfer_rdata_d = {3'h0, crit_q, 2'h0};
        temp_limit_pkg::ADDR_TEMP: xfer_rdata_d = {ge_crit, gt_high, lt_low, temp_q};
        default:                   xfer_rdata_d = 16'h0000;
      endcase
    end
    // Sampling stops while shut down; reading keeps the last sample
    if (sample_valid && !sensor_shutdown_q) begin
      temp_d = sample_temp & temp_limit_pkg::res_mask(temp_limit_pkg::RES_CAP);
    end
    // Set at the limit, release only past it by the hysteresis
    crit_f_d = crit_f_q ? (t >= lc - hv) : ge_crit;
    high_f_d = high_f_q ? (t > lh - hv) : gt_high;
    low_f_d  = low_f_q ? (t < ll + hv) : lt_low;
    crossing = int_mode && ({high_f_d, low_f_d} != {high_f_q, low_f_q});
    // A clear held over critical waits, then runs once below it
    clr_pend_d = (clr_pend_q || clr_req) && crit_f_d && int_mode;
    do_clear   = (clr_pend_q || clr_req) && !crit_f_d;
    event_d    = int_mode && (crossing || (event_q && !do_clear));       // Set wins over clear
    case (amode)
      temp_limit_pkg::MODE_INT:  cond_new = crit_f_q || event_q;
      temp_limit_pkg::MODE_CRIT: cond_new = crit_f_q;
      default:                   cond_new = crit_f_q || high_f_q || low_f_q;
    endcase
    cond_d    = sensor_shutdown_q ? cond_q : cond_new;
    oe_d      = pol_q ? !active : active;
    conv_en_d = !sensor_shutdown_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen_q   <= 1'b0;
      mode_q       <= 1'b0;
      pol_q        <= 1'b0;
      critonly_q   <= 1'b0;
      en_q         <= 1'b0;
      elock_q      <= 1'b0;
      clock_q      <= 1'b0;
      sensor_shutdown_q       <= 1'b0;
      hysteresis_select_q       <= 2'h0;
      high_q       <= 11'h000;
      low_q        <= 11'h000;
      crit_q       <= 11'h000;
      temp_q       <= 13'h0000;
      crit_f_q     <= 1'b0;
      high_f_q     <= 1'b0;
      low_f_q      <= 1'b0;
      event_q      <= 1'b0;
      clr_pend_q   <= 1'b0;
      cond_q       <= 1'b0;
      oe_q         <= 1'b0;
      conv_en_q    <= 1'b0;
      xfer_rdata_q <= 16'h0000;
    end else begin
      req_seen_q   <= req_seen_d;
      mode_q       <= mode_d;
      pol_q        <= pol_d;
      critonly_q   <= critonly_d;
      en_q         <= en_d;
      elock_q      <= elock_d;
      clock_q      <= clock_d;
      sensor_shutdown_q       <= sensor_shutdown_d;
      hysteresis_select_q       <= hysteresis_select_d;
      high_q       <= high_d;
      low_q        <= low_d;
      crit_q       <= crit_d;
      temp_q       <= temp_d;
      crit_f_q     <= crit_f_d;
      high_f_q     <= high_f_d;
      low_f_q      <= low_f_d;
      event_q      <= event_d;
      clr_pend_q   <= clr_pend_d;
      cond_q       <= cond_d;
      oe_q         <= oe_d;
      conv_en_q    <= conv_en_d;
      xfer_rdata_q <= xfer_rdata_d;
    end
  end

  // Open drain: only ever pulls low; the pin's level is not needed here
  assign alert_o     = 1'b0;
  assign alert_oe    = oe_q;
  assign conv_enable = conv_en_q;

  // ---------------- Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_crit_bit_read: assert property (rd_now && addr_l_q == temp_limit_pkg::ADDR_TEMP |=>
    xfer_rdata_q[temp_limit_pkg::TEMP_FLAG_CRIT] == ($past(t) >= $past(lc))) else $error("crit bit wrong");
  a_high_bit_read: assert property (rd_now && addr_l_q == temp_limit_pkg::ADDR_TEMP |=>
    xfer_rdata_q[temp_limit_pkg::TEMP_FLAG_HIGH] == ($past(t) > $past(lh))) else $error("high bit wrong");
  a_low_bit_read: assert property (rd_now && addr_l_q == temp_limit_pkg::ADDR_TEMP |=>
    xfer_rdata_q[temp_limit_pkg::TEMP_FLAG_LOW] == ($past(t) < $past(ll))) else $error("low bit wrong");
  a_reading_body: assert property (rd_now && addr_l_q == temp_limit_pkg::ADDR_TEMP |=>
    xfer_rdata_q[12:0] == $past(temp_q)) else $error("reading body wrong");
  a_limit_zero_bits: assert property (rd_now && addr_l_q == temp_limit_pkg::ADDR_HIGH |=>
    xfer_rdata_q[1:0] == 2'h0 && xfer_rdata_q[15:13] == 3'h0) else $error("limit pad bits set");
  a_res_unused_zero: assert property (
    (temp_q & ~temp_limit_pkg::res_mask(temp_limit_pkg::RES_CAP)) == 13'h0000) else $error("sub-LSB bit set");
  a_int_crit_hold: assert property (int_mode && crit_f_q && !sensor_shutdown_q |=> cond_q)
    else $error("alert released above critical");
  a_clear_deferred: assert property (clr_req && crit_f_d |=> clr_pend_q && event_q == $past(event_q))
    else $error("clear not deferred");
  a_cmp_window: assert property (amode == temp_limit_pkg::MODE_CMP && !sensor_shutdown_q |=>
    cond_q == $past(crit_f_q || high_f_q || low_f_q)) else $error("comparator alert wrong");
  a_critonly_alert: assert property (critonly_q && !sensor_shutdown_q |=> cond_q == $past(crit_f_q))
    else $error("critical-only alert wrong");
  a_sensor_shutdown_freeze: assert property (sensor_shutdown_q ##1 sensor_shutdown_q |-> $stable(temp_q) && $stable(cond_q) && !conv_en_q)
    else $error("state moved during shutdown");
  a_sensor_shutdown_locked: assert property (wr_now && lock && !sensor_shutdown_q |=> !sensor_shutdown_q)
    else $error("shutdown entered while locked");
  a_high_release: assert property (high_f_q && !high_f_d |-> t <= lh - hv)
    else $error("high released inside hysteresis");
  a_pin_polarity: assert property (##1 alert_oe == $past(pol_q ? !active : active))
    else $error("alert pin level wrong");

  c_int_event: cover property (int_mode && !event_q ##1 event_q);
  c_clear_pending: cover property (clr_pend_q ##[1:300] !clr_pend_q && !event_q);
  c_shutdown: cover property (!sensor_shutdown_q ##1 sensor_shutdown_q);
  c_cmp_alert: cover property (amode == temp_limit_pkg::MODE_CMP && en_q && cond_q);
endmodule

// ===== testbench/host_model.sv
`timescale 1ns/1ps
// Host controller model; its link clock runs only inside a frame
module host_model (
  // Register port towards the sensor
  output logic             link_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rd_valid,
  input  wire logic        reg_busy
);
  logic raw = 1'b0;
  logic run = 1'b0;

  // 12 ns free clock, gated while low so no runt pulse leaves the model
  always #6 raw = ~raw;
  assign link_clk = raw & run;

  // Idle levels at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 16'h0000;
  end

  // One frame: idle edges settle the link reset, then one request pulse
  task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    ok = 1'b0;
    q  = 16'h0000;
    @(negedge raw) run = 1'b1;
    repeat (4) @(posedge link_clk);
    reg_wr    <= w;
    reg_rd    <= ~w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge link_clk);
    // Released lines show the inverse, not a stale copy
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    for (int i = 0; i < 40 && ok !== 1'b1; i++) begin
      @(posedge link_clk);
      #1;
      if (reg_rd_valid === 1'b1) q = reg_rdata;
      if (reg_busy === 1'b0) ok = 1'b1;
    end
    @(negedge raw) run = 1'b0;
  endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  // Configuration words
  localparam logic [15:0] INT = 16'h0001, POL = 16'h0002, CO = 16'h0004, EN = 16'h0008;
  localparam logic [15:0] CLR = 16'h0020, LK = 16'h0040, SD = 16'h0100;
  // Stimulus and observed signals
  logic        clk = 1'b0, reset_n = 1'b0, sample_valid = 1'b0;
  logic [12:0] sample_temp = 13'h0000;
  logic        link_clk, reg_wr, reg_rd, reg_rd_valid, reg_busy, conv_enable, alert_o, alert_oe;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic [12:0] hi, lo, cr;
  wire  logic  alert_pin;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #10 clk = ~clk;
  // Open-drain pin with pull-up
  assign alert_pin = alert_oe ? alert_o : 1'b1;

  host_model host_model_inst (.link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_busy(reg_busy));
  temp_limit_event_logic temp_limit_event_logic_inst (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .reg_busy(reg_busy), .sample_valid(sample_valid),
    .sample_temp(sample_temp), .conv_enable(conv_enable), .alert_i(alert_pin), .alert_o(alert_o),
    .alert_oe(alert_oe));

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One register transfer, then time for the alert path to settle
  task automatic xf(input logic w, input logic [3:0] a, input logic [15:0] d);
    logic ok;
    host_model_inst.xfer(w, a, d, q, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      end_sim();
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic cfg(input logic [15:0] v);
    xf(1'b1, temp_limit_pkg::ADDR_CFG, v);
  endtask

  // One converter sample; flags and pin lag it by a few cycles
  task automatic smp(input logic [12:0] t);
    @(posedge clk);
    sample_temp  <= t;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // Expected reading: flags over the signed value
  function automatic logic [15:0] rdg(input logic [12:0] t);
    return {$signed(t) >= $signed(cr), $signed(t) > $signed(hi), $signed(t) < $signed(lo), t};
  endfunction

  task automatic t_reset();
    `CHK(conv_enable, 1'b1)
    `CHK(alert_oe, 1'b0)
    xf(1'b0, temp_limit_pkg::ADDR_CAP, 16'h0000);
    `CHK(q, temp_limit_pkg::CAP_VALUE)
    xf(1'b0, 4'hf, 16'h0000);
    `CHK(q, 16'h0000)
  endtask

  task automatic t_format();
    logic [12:0] tv [8] = '{13'h0320, 13'h0321, 13'h1e70, 13'h1e6f, 13'h04ff, 13'h0500, 13'h1c90, 13'h0001};
    xf(1'b1, temp_limit_pkg::ADDR_HIGH, 16'hffff);
    xf(1'b0, temp_limit_pkg::ADDR_HIGH, 16'h0000);
    `CHK(q, 16'h1ffc)
    hi = 13'h0320;
    lo = 13'h1e70;
    cr = 13'h0500;
    xf(1'b1, temp_limit_pkg::ADDR_HIGH, {3'h0, hi});
    xf(1'b1, temp_limit_pkg::ADDR_LOW, {3'h0, lo});
    xf(1'b1, temp_limit_pkg::ADDR_CRIT, {3'h0, cr});
    xf(1'b0, temp_limit_pkg::ADDR_LOW, 16'h0000);
    `CHK(q, 16'h1e70)
    foreach (tv[i]) begin
      smp(tv[i]);
      xf(1'b0, temp_limit_pkg::ADDR_TEMP, 16'h0000);
      `CHK(q, rdg(tv[i]))
    end
  endtask

  task automatic t_cmp();
    smp(13'h0400);
    `CHK(alert_oe, 1'b0)
    cfg(EN);
    `CHK(alert_oe, 1'b1)
    `CHK(alert_pin, 1'b0)
    xf(1'b0, temp_limit_pkg::ADDR_CFG, 16'h0000);
    `CHK(q[temp_limit_pkg::CFG_MIRROR], 1'b1)
    cfg(EN | POL);
    `CHK(alert_oe, 1'b0)
    xf(1'b0, temp_limit_pkg::ADDR_CFG, 16'h0000);
    `CHK(q[temp_limit_pkg::CFG_MIRROR], 1'b1)
    cfg(POL);
    `CHK(alert_oe, 1'b1)
    xf(1'b0, temp_limit_pkg::ADDR_CFG, 16'h0000);
    `CHK(q[temp_limit_pkg::CFG_MIRROR], 1'b0)
    cfg(EN | CLR);
    `CHK(alert_oe, 1'b1)
    smp(13'h0100);
    `CHK(alert_oe, 1'b0)
    smp(13'h1c90);
    `CHK(alert_oe, 1'b1)
  endtask

  // A limit write alone moves the pin, no new sample needed
  task automatic t_limit();
    smp(13'h0100);
    xf(1'b1, temp_limit_pkg::ADDR_HIGH, 16'h00fc);
    `CHK(alert_oe, 1'b1)
    xf(1'b1, temp_limit_pkg::ADDR_HIGH, 16'h0320);
    `CHK(alert_oe, 1'b0)
  endtask

  task automatic t_int();
    cfg(EN | INT | CLR);
    `CHK(alert_oe, 1'b0)
    smp(13'h0400);
    `CHK(alert_oe, 1'b1)
    cfg(EN | INT | CLR);
    `CHK(alert_oe, 1'b0)
    xf(1'b0, temp_limit_pkg::ADDR_CFG, 16'h0000);
    `CHK(q, EN | INT)
    smp(13'h0100);
    `CHK(alert_oe, 1'b1)
    cfg(EN | INT | CLR);
    `CHK(alert_oe, 1'b0)
  endtask

  task automatic t_crit();
    smp(13'h0600);
    `CHK(alert_oe, 1'b1)
    cfg(EN | INT | CLR);
    `CHK(alert_oe, 1'b1)
    smp(13'h0400);
    `CHK(alert_oe, 1'b0)
    cfg(EN | CO | INT);
    `CHK(alert_oe, 1'b0)
    smp(13'h0600);
    `CHK(alert_oe, 1'b1)
    cfg(EN | CO | CLR);
    `CHK(alert_oe, 1'b1)
    smp(13'h0400);
    `CHK(alert_oe, 1'b0)
  endtask

  // Release point of the high flag for every hysteresis code
  task automatic t_hysteresis_select();
    logic [12:0] hv [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
    for (int i = 0; i < 4; i++) begin
      smp(13'h0100);
      cfg(EN | (16'(i) << temp_limit_pkg::CFG_HYSTERESIS_SELECT_LO));
      smp(13'h0321);
      `CHK(alert_oe, 1'b1)
      smp(13'h0321 - hv[i]);
      `CHK(alert_oe, 1'b1)
      smp(13'h0320 - hv[i]);
      `CHK(alert_oe, 1'b0)
    end
  endtask

  task automatic t_sensor_shutdown();
    cfg(EN);
    smp(13'h0400);
    cfg(EN | SD);
    `CHK(conv_enable, 1'b0)
    smp(13'h0100);
    xf(1'b0, temp_limit_pkg::ADDR_TEMP, 16'h0000);
    `CHK(q, rdg(13'h0400))
    `CHK(alert_oe, 1'b1)
    cfg(SD);
    `CHK(alert_oe, 1'b0)
    cfg(EN);
    `CHK(conv_enable, 1'b1)
    cfg(EN | LK);
    cfg(EN | LK | SD);
    `CHK(conv_enable, 1'b1)
    xf(1'b0, temp_limit_pkg::ADDR_CFG, 16'h0000);
    `CHK(q[temp_limit_pkg::CFG_SENSOR_SHUTDOWN], 1'b0)
  endtask

  // Main sequence; the lock scenario goes last since locks hold until reset
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_format();
    t_cmp();
    t_limit();
    t_int();
    t_crit();
    t_hysteresis_select();
    t_sensor_shutdown();
    end_sim();
  end
endmodule
